// file: bench/bstl_term.sv
// Terminal model that faces the link across the serial line.
// Assumes the bench clock; line levels are low for mark, high for space.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Terminal.
module bstl_term (
	input wire logic clk,
	output logic lineOut,
	input wire logic lineIn
);
	initial lineOut = 1'b0;
	// Sends one frame; a bad stop is space for most of its first half.
	task automatic send(input logic [7:0] b, input int p, input int stops,
		input logic badStop);
		lineOut = 1'b1;
		repeat (p) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			lineOut = ~b[i];
			repeat (p) @(negedge clk);
		end
		lineOut = badStop;
		repeat (badStop ? p / 2 - 2 : 0) @(negedge clk);
		lineOut = 1'b0;
		repeat (p * stops) @(negedge clk);
	endtask : send
	// Takes one frame at mid bit and checks start and stop levels.
	task automatic take(output logic [7:0] b, output logic ok, input int p,
		input int stops);
		int n;
		n = 0;
		ok = 1'b1;
		while (lineIn !== 1'b1 && n < 4000) begin
			n++;
			@(negedge clk);
		end
		repeat (p / 2) @(negedge clk);
		if (lineIn !== 1'b1) ok = 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (p) @(negedge clk);
			b[i] = ~lineIn;
		end
		repeat (stops) begin
			repeat (p) @(negedge clk);
			if (lineIn !== 1'b0) ok = 1'b0;
		end
	endtask : take
endmodule : bstl_term
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench of the link.
// Assumes the link and the terminal model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench.
module tb;
	logic clk, rst, serialInFlag, serialOut, txValid, txReady, rxValid;
	logic rxReady, rxOverrun, rxFrameErr, ok;
	logic [6:0] txCode;
	logic [7:0] got, v;
	bstl_pkg::bstl_char_t rxChar;
	int fails = 0, checked = 0, cycles = 0, ovCnt = 0, feCnt = 0;
	bstl_link #(.MAX_PERIOD(200), .MIN_PERIOD(20),
		.TWO_STOP_PERIOD(150)) DUT (.clk(clk), .rst(rst),
		.serialInFlag(serialInFlag), .serialOut(serialOut),
		.txValid(txValid), .txCode(txCode), .txReady(txReady),
		.rxValid(rxValid), .rxReady(rxReady), .rxChar(rxChar),
		.rxOverrun(rxOverrun), .rxFrameErr(rxFrameErr));
	bstl_term term (.clk(clk), .lineOut(serialInFlag), .lineIn(serialOut));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(negedge clk) begin
		cycles++;
		if (rxOverrun === 1'b1) ovCnt++;
		if (rxFrameErr === 1'b1) feCnt++;
		if (cycles == 60000) begin
			fails++;
			stop_test();
		end
	end
	task automatic check(input string name, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task automatic tx(input logic [6:0] c);
		txCode = c;
		txValid = 1'b1;
		@(negedge clk);
		txValid = 1'b0;
	endtask : tx
	// Sends one character and checks its frame and the stop count.
	task automatic tx_check(input logic [6:0] c, input int p, input int stops);
		fork
			tx(c);
			term.take(got, ok, p, stops);
		join
		check("txChar", got, {^c, c});
		check("txFrame", ok, 1);
		check("txBusy", txReady, 0);
		repeat (p / 2 + 4) @(negedge clk);
		check("txIdle", txReady, 1);
	endtask : tx_check
	// Receives one character and pops it.
	task automatic rx(input logic [7:0] b, input int p);
		int n;
		n = 0;
		term.send(b, p, 1, 1'b0);
		while (rxValid !== 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		check("rxChar", rxChar, {^b, b[6:0]});
		rxReady = 1'b1;
		@(negedge clk);
		rxReady = 1'b0;
		check("rxEmpty", rxValid, 0);
	endtask : rx
	initial begin
		rst = 1'b1;
		txValid = 1'b0;
		txCode = 7'h00;
		rxReady = 1'b0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		check("idleLine", serialOut, 0);
		check("readyRst", txReady, 1);
		tx_check(7'h4d, 200, 2);
		rx(8'h4d, 100);
		rx(8'hcd, 100);
		fork
			tx_check(7'h3a, 100, 1);
			rx(8'h4b, 100);
		join
		rx(8'hb1, 40);
		tx_check(7'h7f, 40, 1);
		term.send(8'h41, 40, 1, 1'b1);
		repeat (4) @(negedge clk);
		check("frameErr", feCnt, 1);
		check("frameDrop", rxValid, 0);
		for (int i = 0; i < 33; i++) begin
			v = 8'(i + 8'h21);
			term.send({^v[6:0], v[6:0]}, 40, 1, 1'b0);
		end
		repeat (4) @(negedge clk);
		check("overrun", ovCnt, 1);
		for (int i = 0; i < 32; i++) begin
			v = 8'(i + 8'h21);
			check("fifoChar", rxChar, {1'b0, v[6:0]});
			rxReady = 1'b1;
			@(negedge clk);
			rxReady = 1'b0;
		end
		check("fifoEmpty", rxValid, 0);
		stop_test();
	end
endmodule : tb
`default_nettype wire

// file: core/bstl_defines.svh
// Constants of the bit serial terminal link.
// Assumes a 20 MHz system clock and a terminal of 110 to 1200 baud.
// Summary of operation
// - Every character is framed by one start bit before its bits and stop bits after them.
// - Two stop bits end a frame at 10 characters per second, one at faster rates.
// - A character has eight bits, seven code bits then the parity bit on top.
// - Parity is one exactly when the seven code bits hold an odd count of ones.
// - The receiver reads a low serial flag input as one (mark) and high as zero.
// - The transmitter drives low for one (mark) and high for zero at each bit time.
// - The transmitter sends the same frame format that the terminal sends.
// - The receiver samples the flag input again and again and assembles each character.
// - The receiver adapts to the terminal character rate with no configuration; its measured period only shrinks, so a slower rate needs a reset.
// - Half and full duplex terminals both work with no change of behaviour.
// - Any terminal rate from 110 to 1200 baud is supported.
`ifndef BSTL_DEFINES_SVH
`define BSTL_DEFINES_SVH
`define BSTL_CLK_HZ 20000000
`define BSTL_MIN_BAUD 110
`define BSTL_MAX_BAUD 1200
`define BSTL_TWO_STOP_BAUD 130
`define BSTL_CODE_BITS 7
`define BSTL_FRAME_BITS 4'h8
`define BSTL_FIFO_DEPTH 32
`define BSTL_MARK 1'b0
`define BSTL_SPACE 1'b1
`endif

// file: core/bstl_link.sv
// Bit serial terminal link with its receive FIFO.
// Assumes one clock, an asynchronous serial flag input and a terminal link.
`timescale 1ns/10ps
`default_nettype none
`include "bstl_defines.svh"
// ==========================================================
// Receive FIFO.
module bstl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `BSTL_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic doWr, doRd;
	always_comb begin
		doWr = inValid && inReady;
		doRd = outValid && outReady;
		wrPtr_nxt = doWr ? wrPtr_r + 1'b1 : wrPtr_r;
		rdPtr_nxt = doRd ? rdPtr_r + 1'b1 : rdPtr_r;
		count_nxt = count_r + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end
	always_ff @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_r] <= inData;
		end
	end
	assign inReady = (count_r != DEPTH[AW:0]);
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
endmodule : bstl_fifo
// ==========================================================
// Link top.
module bstl_link #(
	parameter int CW = 18,
	parameter int MAX_PERIOD = `BSTL_CLK_HZ / `BSTL_MIN_BAUD,
	parameter int MIN_PERIOD = `BSTL_CLK_HZ / `BSTL_MAX_BAUD,
	parameter int TWO_STOP_PERIOD = `BSTL_CLK_HZ / `BSTL_TWO_STOP_BAUD
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic serialInFlag,
	output logic serialOut,
	input wire logic txValid,
	input wire logic [`BSTL_CODE_BITS-1:0] txCode,
	output logic txReady,
	output logic rxValid,
	input wire logic rxReady,
	output bstl_pkg::bstl_char_t rxChar,
	output logic rxOverrun,
	output logic rxFrameErr
);
	function automatic logic evenPar(input logic [`BSTL_CODE_BITS-1:0] c);
		evenPar = ^c;
	endfunction : evenPar
	localparam logic [CW-1:0] GLITCH = CW'(MIN_PERIOD / 2);
	// ==========================================================
	// Input synchroniser.
	logic sync1_r, sync2_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= `BSTL_MARK;
			sync2_r <= `BSTL_MARK;
		end else begin
			sync1_r <= serialInFlag;
			sync2_r <= sync1_r;
		end
	end
	// ==========================================================
	// Receiver with rate measurement.
	bstl_pkg::bstl_state_t rxState_r, rxState_nxt;
	logic [CW-1:0] rxCnt_r, rxCnt_nxt, period_r, period_nxt, half;
	logic [3:0] rxBits_r, rxBits_nxt;
	logic [7:0] rxShift_r, rxShift_nxt;
	logic push_r, push_nxt, ovr_r, ovr_nxt, ferr_r, ferr_nxt;
	logic lineMark, fifoInReady;
	bstl_pkg::bstl_char_t pushChar;
	always_comb begin
		lineMark = (sync2_r == `BSTL_MARK);
		half = {1'b0, period_r[CW-1:1]};
		rxState_nxt = rxState_r;
		rxCnt_nxt = rxCnt_r + 1'b1;
		period_nxt = period_r;
		rxBits_nxt = rxBits_r;
		rxShift_nxt = rxShift_r;
		push_nxt = 1'b0;
		ovr_nxt = 1'b0;
		ferr_nxt = 1'b0;
		case (rxState_r)
			bstl_pkg::ST_IDLE: begin
				rxCnt_nxt = '0;
				rxBits_nxt = '0;
				if (!lineMark) begin
					rxState_nxt = bstl_pkg::ST_START;
				end
			end
			bstl_pkg::ST_START: begin
				if (lineMark) begin
					rxCnt_nxt = '0;
					if (rxCnt_r < GLITCH) begin
						rxState_nxt = bstl_pkg::ST_IDLE;
					end else begin
						rxState_nxt = bstl_pkg::ST_DATA;
						if (rxCnt_r < period_r) begin
							period_nxt = rxCnt_r;
						end
					end
				end else if (rxCnt_r == period_r - 1'b1) begin
					rxCnt_nxt = '0;
					rxState_nxt = bstl_pkg::ST_DATA;
				end
			end
			bstl_pkg::ST_DATA: begin
				if (rxCnt_r == half) begin
					rxShift_nxt = {lineMark, rxShift_r[7:1]};
					rxBits_nxt = rxBits_r + 1'b1;
				end
				if (rxCnt_r == period_r - 1'b1) begin
					rxCnt_nxt = '0;
					if (rxBits_r == `BSTL_FRAME_BITS) begin
						rxState_nxt = bstl_pkg::ST_STOP;
					end
				end
			end
			default: begin
				if (rxCnt_r == half) begin
					rxState_nxt = bstl_pkg::ST_IDLE;
					ferr_nxt = !lineMark;
					push_nxt = lineMark && fifoInReady;
					ovr_nxt = lineMark && !fifoInReady;
				end
			end
		endcase
		pushChar.code = rxShift_r[`BSTL_CODE_BITS-1:0];
		pushChar.parityErr = evenPar(pushChar.code) != rxShift_r[7];
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxState_r <= bstl_pkg::ST_IDLE;
			rxCnt_r <= '0;
			period_r <= CW'(MAX_PERIOD);
			rxBits_r <= '0;
			rxShift_r <= '0;
			push_r <= 1'b0;
			ovr_r <= 1'b0;
			ferr_r <= 1'b0;
		end else begin
			rxState_r <= rxState_nxt;
			rxCnt_r <= rxCnt_nxt;
			period_r <= period_nxt;
			rxBits_r <= rxBits_nxt;
			rxShift_r <= rxShift_nxt;
			push_r <= push_nxt;
			ovr_r <= ovr_nxt;
			ferr_r <= ferr_nxt;
		end
	end
	bstl_pkg::bstl_char_t heldChar_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			heldChar_r <= '0;
		end else begin
			heldChar_r <= pushChar;
		end
	end
	assign rxOverrun = ovr_r;
	assign rxFrameErr = ferr_r;
	bstl_fifo #(.WIDTH($bits(bstl_pkg::bstl_char_t)),
		.DEPTH(`BSTL_FIFO_DEPTH)) rxFifo (
		.clk(clk),
		.rst(rst),
		.inValid(push_r),
		.inReady(fifoInReady),
		.inData(heldChar_r),
		.outValid(rxValid),
		.outReady(rxReady),
		.outData(rxChar)
	);
	// ==========================================================
	// Transmitter, with state of its own for full duplex; its bit time is the receiver's measured period.
	bstl_pkg::bstl_state_t txState_r, txState_nxt;
	logic [CW-1:0] txCnt_r, txCnt_nxt;
	logic [3:0] txBits_r, txBits_nxt;
	logic [7:0] txShift_r, txShift_nxt;
	logic [1:0] txStops_r, txStops_nxt;
	logic txLine_r, txLine_nxt, txReady_r, txReady_nxt;
	always_comb begin
		txState_nxt = txState_r;
		txCnt_nxt = txCnt_r + 1'b1;
		txBits_nxt = txBits_r;
		txShift_nxt = txShift_r;
		txStops_nxt = txStops_r;
		txReady_nxt = txReady_r;
		case (txState_r)
			bstl_pkg::ST_IDLE: begin
				txCnt_nxt = '0;
				txBits_nxt = '0;
				if (txValid && txReady_r) begin
					txShift_nxt = {evenPar(txCode), txCode};
					txState_nxt = bstl_pkg::ST_START;
					txReady_nxt = 1'b0;
				end
			end
			bstl_pkg::ST_START: begin
				if (txCnt_r == period_r - 1'b1) begin
					txCnt_nxt = '0;
					txState_nxt = bstl_pkg::ST_DATA;
				end
			end
			bstl_pkg::ST_DATA: begin
				if (txCnt_r == period_r - 1'b1) begin
					txCnt_nxt = '0;
					txShift_nxt = {1'b0, txShift_r[7:1]};
					txBits_nxt = txBits_r + 1'b1;
					if (txBits_r == `BSTL_FRAME_BITS - 1'b1) begin
						txState_nxt = bstl_pkg::ST_STOP;
						txStops_nxt = (period_r > CW'(TWO_STOP_PERIOD)) ?
							2'h2 : 2'h1;
					end
				end
			end
			default: begin
				if (txCnt_r == period_r - 1'b1) begin
					txCnt_nxt = '0;
					txStops_nxt = txStops_r - 1'b1;
					if (txStops_r == 2'h1) begin
						txState_nxt = bstl_pkg::ST_IDLE;
						txReady_nxt = 1'b1;
					end
				end
			end
		endcase
		case (txState_nxt)
			bstl_pkg::ST_START: txLine_nxt = `BSTL_SPACE;
			bstl_pkg::ST_DATA: begin
				txLine_nxt = txShift_nxt[0] ? `BSTL_MARK : `BSTL_SPACE;
			end
			default: txLine_nxt = `BSTL_MARK;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txState_r <= bstl_pkg::ST_IDLE;
			txCnt_r <= '0;
			txBits_r <= '0;
			txShift_r <= '0;
			txStops_r <= '0;
			txLine_r <= `BSTL_MARK;
			txReady_r <= 1'b1;
		end else begin
			txState_r <= txState_nxt;
			txCnt_r <= txCnt_nxt;
			txBits_r <= txBits_nxt;
			txShift_r <= txShift_nxt;
			txStops_r <= txStops_nxt;
			txLine_r <= txLine_nxt;
			txReady_r <= txReady_nxt;
		end
	end
	assign serialOut = txLine_r;
	assign txReady = txReady_r;
	// ==========================================================
	// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence txTaken;
		txState_r == bstl_pkg::ST_IDLE && txValid && txReady_r;
	endsequence
	sequence startSent;
		serialOut == `BSTL_SPACE && txState_r == bstl_pkg::ST_START;
	endsequence
	idle_line_mark_a: assert property (
		txState_r == bstl_pkg::ST_IDLE |-> serialOut == `BSTL_MARK)
		else $error("Idle line is not mark.");
	tx_start_space_a: assert property (txTaken |=> startSent)
		else $error("Start bit not sent after a taken character.");
	tx_parity_even_a: assert property (
		txState_r == bstl_pkg::ST_START |-> ^txShift_r == 1'b0)
		else $error("Transmit frame parity is odd.");
	tx_two_stop_a: assert property (
		txState_r == bstl_pkg::ST_DATA ##1 txState_r == bstl_pkg::ST_STOP
		|-> txStops_r == ((period_r > CW'(TWO_STOP_PERIOD)) ? 2'h2 : 2'h1))
		else $error("Wrong stop bit count.");
	tx_data_level_a: assert property (
		txState_r == bstl_pkg::ST_DATA |-> serialOut == !txShift_r[0])
		else $error("Data bit level inverted.");
	period_never_grows_a: assert property (
		period_r <= $past(period_r))
		else $error("Measured period grew.");
	rx_start_edge_a: assert property (
		rxState_r == bstl_pkg::ST_IDLE && sync2_r == `BSTL_SPACE
		|=> rxState_r == bstl_pkg::ST_START)
		else $error("Start edge missed.");
	rx_mid_sample_a: assert property (
		rxState_r == bstl_pkg::ST_DATA && rxCnt_r == half
		|=> rxBits_r == $past(rxBits_r) + 4'h1)
		else $error("Mid-bit sample not taken.");
endmodule : bstl_link
`default_nettype wire

// file: core/bstl_pkg.sv
// Types of the bit serial terminal link.
// Assumes bstl_defines.svh is compiled first.
`include "bstl_defines.svh"
package bstl_pkg;
	typedef struct packed {
		logic parityErr;
		logic [`BSTL_CODE_BITS-1:0] code;
	} bstl_char_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_STOP = 2'b11
	} bstl_state_t;
endpackage : bstl_pkg
